// ### bpwc_top.sv
// host clock-run, suspend and ring/wake routing for two sockets
// assumes all inputs synchronous to core_clk except card wake and ring
`timescale 1ns/1ps
module bpwc_top (
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic                          hold_host_clock,
   input  wire logic                          res16_busy,
   input  wire logic                          cb_master_busy,
   input  wire logic                          host_master_posted,
   input  wire logic                          irq_pending,
   input  wire logic                          clkrun_fn_select,
   input  wire logic                          host_clkrun_in,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_ireq,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_cint,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_wake_event,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_ring_in,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_active,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] cclkrun_in,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] creq,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_powered,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_is_16bit,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] card_output_float,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] auto_card_powerdown,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] ring_mask_enable,
   input  wire logic [bpwc_pkg::NUM_SOCK-1:0] status_change_mask,
   input  wire logic                          ring_out_enable,
   input  wire logic                          power_event_enable,
   input  wire logic                          power_event,
   input  wire logic                          ring_pin_select,
   input  wire logic [1:0]                    ring_route,
   input  wire logic                          suspend,
   input  wire logic                          bus_grant,
   input  wire logic                          bus_txn_active,
   input  wire logic                          host_reset_in,
   input  wire logic                          global_reset_in,
   output logic                               multifunction_pin_six_out,
   output logic                               multifunction_pin_six_oe_n,
   output logic                               host_clock_restart,
   output logic [bpwc_pkg::NUM_SOCK-1:0]      cclkrun_out,
   output logic [bpwc_pkg::NUM_SOCK-1:0]      cclkrun_oe_n,
   output logic [bpwc_pkg::NUM_SOCK-1:0]      cclk_stopped,
   output logic [bpwc_pkg::NUM_SOCK-1:0]      card_float,
   output logic [bpwc_pkg::NUM_SOCK-1:0]      card_reset,
   output logic                               host_clk_gate,
   output logic                               host_bus_float,
   output logic                               host_reset_eff,
   output logic                               global_reset_eff,
   output logic                               ring_wake_out,
   output logic                               multifunction_pin_two,
   output logic                               multifunction_pin_four
);
   logic [bpwc_pkg::NUM_SOCK-1:0] wake_s1_reg, wake_s2_reg, ring_s1_reg, ring_s2_reg;
   logic [bpwc_pkg::NUM_SOCK-1:0] wake_s2_next, ring_s2_next;
   logic                          refuse_stop;
   logic                          restart_req;
   logic                          drive_reg, drive_next;
   logic                          gate_reg, gate_next;
   logic                          ring_fn, ring_reg, ring_next;
   logic                          two_reg, two_next, four_reg, four_next;

   // ---------------------------------------------------------------
   // input synchronisers and socket managers
   // ---------------------------------------------------------------
   always_comb begin
      wake_s2_next = wake_s1_reg;
      ring_s2_next = ring_s1_reg;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_s1_reg <= '0;
         wake_s2_reg <= '0;
         ring_s1_reg <= '0;
         ring_s2_reg <= '0;
      end else begin
         wake_s1_reg <= card_wake_event;
         wake_s2_reg <= wake_s2_next;
         ring_s1_reg <= card_ring_in;
         ring_s2_reg <= ring_s2_next;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < bpwc_pkg::NUM_SOCK; gi++) begin : g_sock
         bpwc_sock u_sock (
            .core_clk            (core_clk),
            .rst_n               (rst_n),
            .card_active         (card_active[gi]),
            .cclkrun_in          (cclkrun_in[gi]),
            .creq                (creq[gi]),
            .card_output_float   (card_output_float[gi]),
            .auto_card_powerdown (auto_card_powerdown[gi]),
            .cclk_stopped        (cclk_stopped[gi]),
            .cclkrun_out         (cclkrun_out[gi]),
            .cclkrun_oe_n        (cclkrun_oe_n[gi]),
            .card_float          (card_float[gi]),
            .card_reset          (card_reset[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // host clock-run
   // ---------------------------------------------------------------
   // status-change over serial interrupts also raises a restart first
   always_comb begin
      refuse_stop = hold_host_clock
                 || res16_busy || cb_master_busy || host_master_posted
                 || irq_pending || !(&cclk_stopped);
      restart_req = (|card_ireq) || (|card_cint)
                 || (|wake_s2_reg) || (|ring_s2_reg)
                 || (|(~cclkrun_in)) || (|creq);
      // assert clkrun (low) to refuse a stop the central resource probes, or to restart
      drive_next  = clkrun_fn_select && ((host_clkrun_in && refuse_stop) || restart_req);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_reg <= 1'b0;
      end else begin
         drive_reg <= drive_next;
      end
   end

   assign multifunction_pin_six_out  = 1'b0;
   assign multifunction_pin_six_oe_n = !drive_reg;
   assign host_clock_restart         = drive_reg;

   // ---------------------------------------------------------------
   // suspend
   // ---------------------------------------------------------------
   // power switch runs on its own clock outside this block
   always_comb begin
      gate_next = suspend && !(gate_reg == 1'b0 && bus_grant && bus_txn_active);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_reg <= 1'b0;
      end else begin
         gate_reg <= gate_next;
      end
   end

   assign host_clk_gate    = gate_reg;
   assign host_bus_float   = suspend;
   assign host_reset_eff   = host_reset_in && !suspend;
   assign global_reset_eff = global_reset_in && !suspend;

   // ---------------------------------------------------------------
   // ring and wake routing, kept live in suspend
   // ---------------------------------------------------------------
   always_comb begin
      ring_fn    = ring_out_enable &&
                   (|(ring_s2_reg & ring_mask_enable & card_powered & card_is_16bit)
                 || |(wake_s2_reg & status_change_mask));
      two_next   = 1'b0;
      four_next  = 1'b0;
      if (ring_pin_select == bpwc_pkg::PIN_SEL_SHARED) begin
         // ring wins the shared pin whenever enabled
         ring_next = ring_out_enable ? ring_fn : (power_event_enable && power_event);
      end else begin
         ring_next = power_event_enable && power_event;
         two_next  = ring_fn && (ring_route == bpwc_pkg::RING_ROUTE_TWO);
         four_next = ring_fn && (ring_route == bpwc_pkg::RING_ROUTE_FOUR);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ring_reg <= 1'b0;
         two_reg  <= 1'b0;
         four_reg <= 1'b0;
      end else begin
         ring_reg <= ring_next;
         two_reg  <= two_next;
         four_reg <= four_next;
      end
   end

   assign ring_wake_out          = ring_reg;
   assign multifunction_pin_two  = two_reg;
   assign multifunction_pin_four = four_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_HOLD_CLOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clkrun_fn_select && hold_host_clock && host_clkrun_in) |=> !multifunction_pin_six_oe_n)
      else $error("hold bit did not refuse stop");
   AST_BUSY_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clkrun_fn_select && host_clkrun_in && (res16_busy || cb_master_busy || host_master_posted))
      |=> host_clock_restart)
      else $error("busy did not keep clock");
   AST_IRQ_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clkrun_fn_select && host_clkrun_in && (irq_pending || !(&cclk_stopped)))
      |=> host_clock_restart)
      else $error("pending work did not keep clock");
   AST_IREQ_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clkrun_fn_select && (|card_ireq || |card_cint)) |=> host_clock_restart)
      else $error("card interrupt did not restart clock");
   AST_WAKE_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clkrun_fn_select && |card_wake_event)[*3] |=> host_clock_restart)
      else $error("wake did not restart clock");
   AST_CREQ_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clkrun_fn_select && |creq) |=> host_clock_restart)
      else $error("card request did not restart clock");
   AST_NO_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
      !clkrun_fn_select |=> multifunction_pin_six_oe_n)
      else $error("pin six driven while not selected");
   AST_SUSP_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
      suspend |-> !host_reset_eff && !global_reset_eff && host_bus_float)
      else $error("reset passed during suspend");
   AST_GATE_DELAY: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!gate_reg && suspend && bus_grant && bus_txn_active) |=> !host_clk_gate)
      else $error("gate during transaction");
   AST_GATE_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (suspend && !bus_txn_active)[*2] |-> host_clk_gate)
      else $error("host clock not gated");
   AST_SHARED_RING: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ring_pin_select == bpwc_pkg::PIN_SEL_SHARED && ring_out_enable && !ring_fn)
      |=> !ring_wake_out)
      else $error("power event leaked onto shared ring pin");
   AST_SPLIT_PME: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ring_pin_select == bpwc_pkg::PIN_SEL_SPLIT)
      |=> ring_wake_out == $past(power_event_enable && power_event))
      else $error("power event not on shared pin");
   AST_RING_MASK: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ring_mask_enable == '0 && status_change_mask == '0) |=> !two_reg && !four_reg)
      else $error("masked ring passed");

   COV_RESTART:  cover property (@(posedge core_clk) disable iff (!rst_n) $rose(host_clock_restart));
   COV_SUSPEND:  cover property (@(posedge core_clk) disable iff (!rst_n) $rose(host_clk_gate));
   COV_RING:     cover property (@(posedge core_clk) disable iff (!rst_n) $rose(ring_wake_out));
   COV_RING_TWO: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(multifunction_pin_two));
endmodule

// ### bpwc_pkg.sv
// package for the bridge power and wake control block
// assumes one host clock domain; card wake and ring inputs arrive as raw levels
//
// Behaviour
// - hold-host-clock bit refuses host clock stop
// - busy engines or posted data keep clock
// - pending interrupt or running card clock refuses stop
// - card IREQ or CINT requests clock restart
// - wake, status-change or ring requests restart
// - card CCLKRUN or CREQ requests restart
// - clock-run signalling on multifunction pin six
// - idle socket card clock stopped via CCLKRUN
// - card output float also resets 16-bit card
// - auto powerdown floats when idle, no reset
// - suspend blocks resets and gates host clock
// - power switch clocked from pin or oscillator
// - serial interrupt needs host clock restarted first
// - registers kept through resets during suspend
// - suspend floats bus, gating waits for transaction
// - pins and ring output live during suspend
// - ring passes only with ring mask enable
// - card wake passes only with status mask
// - ring and power event need their enables
// - select zero: shared pin carries ring, or power event while ring output disabled
// - select one: power event shared, ring elsewhere
package bpwc_pkg;
   localparam int          NUM_SOCK       = 2;
   localparam int          SYNC_STAGES    = 2;
   // card clock idle time before stop request
   localparam int          CARD_IDLE_NS   = 1000;
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          CARD_IDLE_CYC  = (CARD_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W          = 8;
   localparam logic        PIN_SEL_SHARED = 1'b0;
   localparam logic        PIN_SEL_SPLIT  = 1'b1;
   localparam logic [1:0]  RING_ROUTE_TWO  = 2'h1;
   localparam logic [1:0]  RING_ROUTE_FOUR = 2'h2;
   localparam logic [CNT_W-1:0] CNT_RESET  = 8'h00;

   typedef enum logic [1:0] {
      BPWC_CC_RUN  = 2'b00,
      BPWC_CC_REQ  = 2'b01,
      BPWC_CC_STOP = 2'b11
   } bpwc_cclk_t;
endpackage

// ### bpwc_sock.sv
// per-socket card clock manager and card power-down control
// assumes card inputs already synchronised to core_clk
`timescale 1ns/1ps
module bpwc_sock (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic card_active,
   input  wire logic cclkrun_in,
   input  wire logic creq,
   input  wire logic card_output_float,
   input  wire logic auto_card_powerdown,
   output logic      cclk_stopped,
   output logic      cclkrun_out,
   output logic      cclkrun_oe_n,
   output logic      card_float,
   output logic      card_reset
);
   bpwc_pkg::bpwc_cclk_t        st_reg, st_next;
   logic [bpwc_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
   logic                        flt_reg, flt_next;
   logic                        rst_reg, rst_next;

   // ---------------------------------------------------------------
   // card clock-run negotiation
   // ---------------------------------------------------------------
   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      unique case (st_reg)
         bpwc_pkg::BPWC_CC_RUN: begin
            if (card_active || creq) begin
               cnt_next = bpwc_pkg::CNT_RESET;
            end else if (cnt_reg == bpwc_pkg::CARD_IDLE_CYC[bpwc_pkg::CNT_W-1:0]) begin
               st_next = bpwc_pkg::BPWC_CC_REQ;
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         bpwc_pkg::BPWC_CC_REQ: begin
            // card holds cclkrun low to refuse the stop
            if (card_active || creq || !cclkrun_in) begin
               st_next  = bpwc_pkg::BPWC_CC_RUN;
               cnt_next = bpwc_pkg::CNT_RESET;
            end else begin
               st_next = bpwc_pkg::BPWC_CC_STOP;
            end
         end
         bpwc_pkg::BPWC_CC_STOP: begin
            if (card_active || creq || !cclkrun_in) begin
               st_next  = bpwc_pkg::BPWC_CC_RUN;
               cnt_next = bpwc_pkg::CNT_RESET;
            end
         end
         default: st_next = bpwc_pkg::BPWC_CC_RUN;
      endcase
   end

   // ---------------------------------------------------------------
   // 16-bit card float and reset
   // ---------------------------------------------------------------
   always_comb begin
      flt_next = card_output_float || (auto_card_powerdown && !card_active);
      rst_next = card_output_float;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg  <= bpwc_pkg::BPWC_CC_RUN;
         cnt_reg <= bpwc_pkg::CNT_RESET;
         flt_reg <= 1'b0;
         rst_reg <= 1'b0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         flt_reg <= flt_next;
         rst_reg <= rst_next;
      end
   end

   assign cclk_stopped = (st_reg == bpwc_pkg::BPWC_CC_STOP);
   // drive cclkrun high during the stop request, else release
   assign cclkrun_out  = 1'b1;
   assign cclkrun_oe_n = (st_reg != bpwc_pkg::BPWC_CC_REQ);
   assign card_float   = flt_reg;
   assign card_reset   = rst_reg;

   AST_FLOAT_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
      card_output_float |=> card_float && card_reset)
      else $error("card output float did not float and reset");
   AST_AUTO_NORESET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (auto_card_powerdown && !card_output_float && !card_active) |=> card_float && !card_reset)
      else $error("auto powerdown misbehaved");
   AST_IDLE_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg == bpwc_pkg::BPWC_CC_REQ && !card_active && !creq && cclkrun_in)
      |=> cclk_stopped)
      else $error("idle card clock not stopped");
   COV_CARD_STOP: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(cclk_stopped));
endmodule

// ### bpwc_host_model.sv
// host bus central clock resource and arbiter model
// assumes the bench asks for stop proposals and bus transactions
`timescale 1ns/1ps
module bpwc_host_model (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic want_stop,
   input  wire logic want_txn,
   input  wire logic six_out,
   input  wire logic six_oe_n,
   output logic      host_clkrun_in,
   output logic      bus_grant,
   output logic      bus_txn_active
);
   logic stop_reg;
   logic stop_next;
   logic prop_reg;
   logic prop_next;
   logic txn_reg;
   logic txn_next;

   // ---------------------------------------------
   // wire level and grant
   // ---------------------------------------------
   assign host_clkrun_in = six_oe_n ? stop_reg : six_out;
   // grant only with a live transaction, never parked
   assign bus_grant      = txn_reg;
   assign bus_txn_active = txn_reg;

   always_comb begin
      prop_next = want_stop;
      // proposal withdrawn once the device pulls the wire low
      stop_next = want_stop & (host_clkrun_in | ~prop_reg);
      txn_next  = want_txn;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_reg <= 1'b0;
         prop_reg <= 1'b0;
         txn_reg  <= 1'b0;
      end else begin
         stop_reg <= stop_next;
         prop_reg <= prop_next;
         txn_reg  <= txn_next;
      end
   end
endmodule

// ### test_bridge_power_wake_control.sv
// self-checking bench for the bridge power and wake block
// assumes bpwc_pkg, bpwc_top and bpwc_host_model are compiled first
`timescale 1ns/1ps
module test_bridge_power_wake_control;
   localparam int NS = bpwc_pkg::NUM_SOCK;
   logic core_clk, rst_n, hold_host_clock, res16_busy, cb_master_busy, host_master_posted;
   logic irq_pending, clkrun_fn_select, host_clkrun_in, ring_out_enable, power_event_enable;
   logic power_event, ring_pin_select, suspend, bus_grant, bus_txn_active, host_reset_in;
   logic global_reset_in, want_stop, want_txn, multifunction_pin_six_out;
   logic multifunction_pin_six_oe_n, host_clock_restart, host_clk_gate, host_bus_float;
   logic host_reset_eff, global_reset_eff, ring_wake_out, multifunction_pin_two;
   logic multifunction_pin_four;
   logic [1:0]    ring_route;
   logic [NS-1:0] card_ireq, card_cint, card_wake_event, card_ring_in, card_active, cclkrun_in;
   logic [NS-1:0] creq, card_powered, card_is_16bit, card_output_float, auto_card_powerdown;
   logic [NS-1:0] ring_mask_enable, status_change_mask, card_pull, sm;
   logic [NS-1:0] cclkrun_out, cclkrun_oe_n, cclk_stopped, card_float, card_reset;
   int            bad_count, n_tests, seed, lo;
   logic [31:0]   rv;

   // ---------------------------------------------
   // card wire, design and host partner
   // ---------------------------------------------
   assign cclkrun_in = (~cclkrun_oe_n & cclkrun_out) | (cclkrun_oe_n & ~card_pull);
   bpwc_top uut (.core_clk, .rst_n, .hold_host_clock, .res16_busy, .cb_master_busy,
      .host_master_posted, .irq_pending, .clkrun_fn_select, .host_clkrun_in, .card_ireq,
      .card_cint, .card_wake_event, .card_ring_in, .card_active, .cclkrun_in, .creq,
      .card_powered, .card_is_16bit, .card_output_float, .auto_card_powerdown,
      .ring_mask_enable, .status_change_mask, .ring_out_enable, .power_event_enable,
      .power_event, .ring_pin_select, .ring_route, .suspend, .bus_grant, .bus_txn_active,
      .host_reset_in, .global_reset_in, .multifunction_pin_six_out,
      .multifunction_pin_six_oe_n, .host_clock_restart, .cclkrun_out, .cclkrun_oe_n,
      .cclk_stopped, .card_float, .card_reset, .host_clk_gate, .host_bus_float,
      .host_reset_eff, .global_reset_eff, .ring_wake_out, .multifunction_pin_two,
      .multifunction_pin_four);
   bpwc_host_model host (.core_clk, .rst_n, .want_stop, .want_txn,
      .six_out(multifunction_pin_six_out), .six_oe_n(multifunction_pin_six_oe_n),
      .host_clkrun_in, .bus_grant, .bus_txn_active);

   always #20 core_clk = ~core_clk;

   // ---------------------------------------------
   // tasks and expectations
   // ---------------------------------------------
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic watch(input int n);
      lo = 0;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         if (multifunction_pin_six_oe_n !== 1'b1) lo++;
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic quiet;
      {hold_host_clock, res16_busy, cb_master_busy, host_master_posted, irq_pending} <= 5'h00;
      {card_ireq, card_cint, creq, card_pull, card_wake_event, card_ring_in} <= 12'h000;
      card_active <= 2'h0;
      want_stop <= 1'b0;
   endtask
   task automatic poke(input int k);
      case (k)
         0: hold_host_clock <= 1'b1;
         1: res16_busy <= 1'b1;
         2: cb_master_busy <= 1'b1;
         3: host_master_posted <= 1'b1;
         4: irq_pending <= 1'b1;
         5: card_active <= sm;
         6: card_ireq <= sm;
         7: card_cint <= sm;
         8: creq <= sm;
         9: card_pull <= sm;
         10: card_wake_event <= sm;
         default: card_ring_in <= sm;
      endcase
   endtask
   task automatic clk_case(input int k, input logic fn);
      @(posedge core_clk);
      quiet();
      clkrun_fn_select <= fn;
      card_is_16bit <= (k == 11) ? 2'h3 : 2'h0;
      sm = 2'b01 << ($random(seed) & 1);
      tick(40);
      #1;
      chk(8'h0F, 8'({cclk_stopped, cclkrun_oe_n}));
      @(posedge core_clk);
      if (k < 6) poke(k);
      want_stop <= 1'b1;
      watch(4);
      if (k >= 6) begin
         chk(8'h00, 8'(lo != 0));
         @(posedge core_clk);
         poke(k);
         watch(8);
         chk(8'(fn), 8'(host_clock_restart));
      end
      chk(8'(fn), 8'(lo != 0));
      $display("clock case %0d select %0d done", k, fn);
   endtask
   function automatic logic [2:0] exp_pins();
      logic r;
      logic p;
      r = ring_out_enable & ((|(card_ring_in & ring_mask_enable & card_powered & card_is_16bit))
          | (|(card_wake_event & status_change_mask)));
      p = power_event_enable & power_event;
      if (ring_pin_select == bpwc_pkg::PIN_SEL_SHARED) return {ring_out_enable ? r : p, 2'b00};
      return {p, r & (ring_route == bpwc_pkg::RING_ROUTE_TWO),
              r & (ring_route == bpwc_pkg::RING_ROUTE_FOUR)};
   endfunction

   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial begin
      seed = 32'h94B7A8A1;
      {core_clk, rst_n, hold_host_clock, res16_busy, cb_master_busy, host_master_posted} = '0;
      {irq_pending, clkrun_fn_select, ring_out_enable, power_event_enable, power_event} = '0;
      {ring_pin_select, suspend, host_reset_in, global_reset_in, want_stop, want_txn} = '0;
      {ring_route, card_ireq, card_cint, card_wake_event, card_ring_in, card_active} = '0;
      {creq, card_is_16bit, card_output_float, auto_card_powerdown, card_pull} = '0;
      {card_powered, ring_mask_enable, status_change_mask} = 6'h3F;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      tick(2);
      for (int f = 1; f >= 0; f--) begin
         for (int k = 0; k < 12; k++) clk_case(k, f[0]);
      end
      card_is_16bit <= 2'h1;
      for (int i = 0; i < 40; i++) begin
         @(posedge core_clk);
         rv = $random(seed);
         if (i == 0) rv = 32'h00000715;
         if (i == 1) rv = 32'h00001F15;
         {card_wake_event, card_ring_in} <= {rv[1], 2'b00, rv[0]};
         {card_powered, ring_mask_enable, status_change_mask, ring_out_enable, power_event_enable,
          power_event, ring_pin_select, ring_route, card_output_float, auto_card_powerdown,
          card_active} <= rv[19:2];
         tick(5);
         #1;
         chk(8'(exp_pins()), 8'({ring_wake_out, multifunction_pin_two, multifunction_pin_four}));
         chk(8'({card_output_float | (auto_card_powerdown & ~card_active), card_output_float}),
             8'({card_float, card_reset}));
      end
      $display("routing and power-down test done");
      @(posedge core_clk);
      {host_reset_in, global_reset_in, want_txn} <= 3'b111;
      {card_wake_event, card_ring_in, ring_out_enable, ring_pin_select} <= 6'h06;
      {card_powered, ring_mask_enable} <= 4'hF;
      tick(3);
      #1;
      chk(8'h03, 8'({host_reset_eff, global_reset_eff}));
      @(posedge core_clk);
      suspend <= 1'b1;
      tick(5);
      #1;
      chk(8'h11, 8'({host_bus_float, host_reset_eff, global_reset_eff, host_clk_gate,
                     ring_wake_out}));
      @(posedge core_clk);
      want_txn <= 1'b0;
      tick(4);
      #1;
      chk(8'h01, 8'(host_clk_gate));
      $display("suspend test done");
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      $display("watchdog expired at %0t", $time);
      wrap_up();
   end
endmodule
